// ---- rtl/fclpc_pkg.sv ----
// constants, register map and carrier types of the full-closed loop position control block
package fclpc_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;
    localparam int POS_W = 32;

    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_BLEND_TC = 12'h196;
    localparam logic [ADDR_W-1:0] ADDR_EXCESS_TOL = 12'h1a0;
    localparam logic [ADDR_W-1:0] ADDR_SW_POLICY = 12'h1a8;
    localparam logic [ADDR_W-1:0] ADDR_AUTO_RESET = 12'h1aa;
    localparam logic [ADDR_W-1:0] ADDR_SW_PATH = 12'h1ac;
    localparam logic [ADDR_W-1:0] ADDR_ASSIST = 12'h2a0;
    localparam logic [ADDR_W-1:0] ADDR_HOME_SRC = 12'h2a2;
    localparam logic [ADDR_W-1:0] ADDR_CAPTURE = 12'h2a4;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 12'h300;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 12'h302;
    localparam logic [ADDR_W-1:0] ADDR_STATE = 12'h304;
    localparam logic [ADDR_W-1:0] ADDR_DEV_LO = 12'h306;
    localparam logic [ADDR_W-1:0] ADDR_DEV_HI = 12'h308;

    // reset values and the blend constant limit
    localparam logic [DATA_W-1:0] RST_BLEND_TC = 16'h0064;
    localparam logic [DATA_W-1:0] MAX_BLEND_TC = 16'h03e8;
    localparam logic [DATA_W-1:0] RST_EXCESS_TOL = 16'h7530;
    localparam logic [DATA_W-1:0] RST_SW_POLICY = 16'h0000;
    localparam logic [DATA_W-1:0] RST_AUTO_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] RST_SW_PATH = 16'h0000;
    localparam logic [DATA_W-1:0] RST_ASSIST = 16'h0000;
    localparam logic [DATA_W-1:0] RST_HOME_SRC = 16'h0000;
    localparam logic [DATA_W-1:0] RST_CAPTURE = 16'h0001;

    // field positions
    localparam int ASSIST_LINK_DET_BIT = 5;
    localparam int SW_PATH_EN_BIT = 15;
    localparam int HOME_INDEX_BIT = 0;
    localparam int CAPTURE_EN_BIT = 0;
    localparam int IRQ_EXCESS = 0;
    localparam int IRQ_LINK_LOST = 1;
    localparam int IRQ_SWITCHED = 2;
    localparam int IRQ_HOMED = 3;
    localparam int IRQ_W = 4;

    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int CTRL_PERIOD_NS = 100000;
    localparam int CTRL_PERIOD_CYC = (CTRL_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CTRL_PER_MS = 1000000 / CTRL_PERIOD_NS;
    localparam int LINK_TIMEOUT_NS = 200000;
    localparam int LINK_TIMEOUT_CYC = (LINK_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } fclpc_req_t;

    // homing sequence
    typedef enum logic [2:0] {
        H_IDLE = 3'b001,
        H_RUN = 3'b010,
        H_ALIGN = 3'b100
    } fclpc_home_t;
endpackage

// ---- rtl/fclpc_ctrl.sv ----
// full-closed loop position control: feedback blend, loop switching, deviation and homing
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ns
module fclpc_ctrl
#(
    parameter int CTRL_CYC = fclpc_pkg::CTRL_PERIOD_CYC,
    parameter int LINK_CYC = fclpc_pkg::LINK_TIMEOUT_CYC
)
(
    input wire logic clk_i, // 20 MHz clock
    input wire logic rstn_i, // synchronous reset, active low
    input wire fclpc_pkg::fclpc_req_t req_i, // register port request
    output logic [fclpc_pkg::DATA_W-1:0] rdata_o, // read data, cycle after read
    input wire logic loop_select_input_i, // pin: high semi, low full
    input wire logic deviation_clear_input_i, // pin: rising edge clears deviation
    input wire logic [fclpc_pkg::POS_W-1:0] enc_pos_i, // main encoder position
    input wire logic [fclpc_pkg::POS_W-1:0] scale_pos_i, // linear scale position
    input wire logic scale_valid_i, // pulse per good scale frame
    input wire logic [fclpc_pkg::POS_W-1:0] cmd_pos_i, // position command
    input wire logic homing_i, // high while homing runs
    output logic [fclpc_pkg::POS_W-1:0] fb_pos_o, // blended feedback position
    output logic [fclpc_pkg::POS_W-1:0] pos_err_o, // position error
    output logic semi_closed_o, // current loop type
    output logic path_start_o, // one-cycle path program start
    output logic [7:0] path_program_number_o, // path program to run
    output logic soft_limit_en_o, // software limit checking active
    output logic excess_deviation_alarm_o, // sticky alarm level
    output logic scale_link_lost_alarm_o, // sticky alarm level
    output logic irq_o // unmasked status pending
);
    import fclpc_pkg::*;

    if (CTRL_CYC < 2 || CTRL_CYC > 65535 || LINK_CYC < 2 || LINK_CYC > 65535)
    begin : g_chk
        $error("fclpc_ctrl: cycle counts out of range");
    end

    typedef struct packed {
        logic [DATA_W-1:0] blend_tc;
        logic [DATA_W-1:0] excess_tol;
        logic policy;
        logic [DATA_W-1:0] auto_tol;
        logic [DATA_W-1:0] sw_path;
        logic [DATA_W-1:0] assist;
        logic [DATA_W-1:0] home_src;
        logic [DATA_W-1:0] capture;
        logic [IRQ_W-1:0] irq_st;
        logic [IRQ_W-1:0] irq_mask;
        logic lsel_s1;
        logic lsel_s2;
        logic clr_s1;
        logic clr_s2;
        logic clr_q;
        logic semi;
        logic [POS_W-1:0] dev_base;
        logic [POS_W-1:0] filt;
        logic [POS_W-1:0] dev_prev;
        logic [POS_W-1:0] err_off;
        logic [POS_W-1:0] fb;
        logic [POS_W-1:0] err;
        logic [15:0] tick_cnt;
        logic [15:0] link_cnt;
        fclpc_home_t hstate;
        logic path_start;
        logic [7:0] path_num;
        logic [DATA_W-1:0] rdata;
    } fclpc_state_t;

    fclpc_state_t s;
    fclpc_state_t next_s;

    // magnitude of a two's complement position
    function automatic logic [POS_W-1:0] mag(input logic [POS_W-1:0] v);
        mag = v[POS_W-1] ? (~v + 32'h0000_0001) : v;
    endfunction

    // filter shift: smallest k with 2^k >= time constant in control cycles
    function automatic logic [4:0] blend_shift(input logic [DATA_W-1:0] tc);
        logic [19:0] k;
        logic [4:0] sh;
        k = 20'(tc) * 20'(CTRL_PER_MS);
        sh = 5'h00;
        for (int i = 0; i < 20; i++)
        begin
            if ((20'h00001 << i) < k)
            begin
                sh = 5'(i + 1);
            end
        end
        blend_shift = sh;
    endfunction

    logic tick;
    logic [POS_W-1:0] diff;
    logic [POS_W-1:0] dev_abs;
    logic [POS_W-1:0] fb_new;
    logic signed [POS_W-1:0] step;
    logic lsel_change;
    logic clr_rise;
    logic [IRQ_W-1:0] irq_set;
    logic wr_hit_irq;

    assign tick = (s.tick_cnt == 16'(CTRL_CYC - 1));
    assign diff = scale_pos_i - enc_pos_i - s.dev_base;
    assign dev_abs = mag(diff);
    // signed step keeps the shift arithmetic when the scale lags the encoder
    assign step = $signed(diff - s.filt) >>> blend_shift(s.blend_tc);
    assign lsel_change = (s.lsel_s2 != s.semi);
    assign clr_rise = s.clr_s2 & ~s.clr_q;
    assign wr_hit_irq = req_i.wr && (req_i.addr == ADDR_IRQ_STATUS);

    // next state
    always_comb
    begin
        next_s = s;
        irq_set = '0;
        next_s.path_start = 1'b0;
        next_s.rdata = '0;

        // pins pass two flops before use
        next_s.lsel_s1 = loop_select_input_i;
        next_s.lsel_s2 = s.lsel_s1;
        next_s.clr_s1 = deviation_clear_input_i;
        next_s.clr_s2 = s.clr_s1;
        next_s.clr_q = s.clr_s2;

        // control cycle timebase
        next_s.tick_cnt = tick ? 16'h0000 : s.tick_cnt + 16'h0001;

        // register writes
        if (req_i.wr)
        begin
            case (req_i.addr)
                ADDR_BLEND_TC: next_s.blend_tc = (req_i.wdata > MAX_BLEND_TC) ?
                    MAX_BLEND_TC : req_i.wdata;
                ADDR_EXCESS_TOL: next_s.excess_tol = req_i.wdata;
                ADDR_SW_POLICY: next_s.policy = req_i.wdata[0];
                ADDR_AUTO_RESET: next_s.auto_tol = req_i.wdata;
                ADDR_SW_PATH: next_s.sw_path = req_i.wdata;
                ADDR_ASSIST: next_s.assist = req_i.wdata;
                ADDR_HOME_SRC: next_s.home_src = req_i.wdata;
                ADDR_CAPTURE: next_s.capture = req_i.wdata;
                ADDR_IRQ_MASK: next_s.irq_mask = req_i.wdata[IRQ_W-1:0];
                default: next_s.irq_mask = s.irq_mask;
            endcase
        end

        // filter the scale-minus-encoder difference once per control cycle
        if (tick)
        begin
            if (s.blend_tc == 16'h0000)
            begin
                next_s.filt = diff;
            end
            else if (step == '0)
            begin
                // a step that rounds to nothing snaps onto the target, so no residue
                next_s.filt = diff;
            end
            else
            begin
                // power-of-two gain keeps this divider-free
                next_s.filt = s.filt + $unsigned(step);
            end
            // alarm only while deviation is both large and still growing
            if (dev_abs > POS_W'(s.excess_tol) && dev_abs > s.dev_prev)
            begin
                irq_set[IRQ_EXCESS] = 1'b1;
            end
            next_s.dev_prev = dev_abs;
            if (s.auto_tol != 16'h0000 && dev_abs <= POS_W'(s.auto_tol))
            begin
                next_s.dev_base = scale_pos_i - enc_pos_i;
                next_s.filt = '0;
                next_s.dev_prev = '0;
            end
        end

        // explicit clear edge
        if (clr_rise)
        begin
            next_s.dev_base = scale_pos_i - enc_pos_i;
            next_s.filt = '0;
            next_s.dev_prev = '0;
        end

        // scale link watchdog, only armed in full-closed loop with bit5 set
        if (scale_valid_i || s.semi || !s.assist[ASSIST_LINK_DET_BIT])
        begin
            next_s.link_cnt = 16'h0000;
        end
        else if (s.link_cnt != 16'(LINK_CYC - 1))
        begin
            next_s.link_cnt = s.link_cnt + 16'h0001;
        end
        if (!s.semi && s.assist[ASSIST_LINK_DET_BIT] && !scale_valid_i &&
            s.link_cnt == 16'(LINK_CYC - 2))
        begin
            irq_set[IRQ_LINK_LOST] = 1'b1;
        end

        // homing sequence
        case (s.hstate)
            H_IDLE:
            begin
                if (homing_i)
                begin
                    next_s.hstate = H_RUN;
                end
            end
            H_RUN:
            begin
                if (s.home_src[HOME_INDEX_BIT])
                begin
                    next_s.capture[CAPTURE_EN_BIT] = 1'b0;
                end
                if (!homing_i)
                begin
                    next_s.hstate = H_ALIGN;
                end
            end
            H_ALIGN:
            begin
                next_s.dev_base = scale_pos_i - enc_pos_i;
                next_s.filt = '0;
                next_s.dev_prev = '0;
                irq_set[IRQ_HOMED] = 1'b1;
                next_s.hstate = H_IDLE;
            end
            default: next_s.hstate = H_IDLE;
        endcase

        // loop type follows synced select level
        next_s.semi = s.lsel_s2;
        if (next_s.semi)
        begin
            fb_new = enc_pos_i;
        end
        else if (s.blend_tc == 16'h0000)
        begin
            fb_new = enc_pos_i + diff;
        end
        else
        begin
            fb_new = enc_pos_i + next_s.filt;
        end

        // error handling at a loop change
        if (lsel_change)
        begin
            irq_set[IRQ_SWITCHED] = 1'b1;
            if (!s.policy)
            begin
                next_s.err_off = cmd_pos_i - fb_new;
            end
            else
            begin
                // command carries over; full-closed return takes up the gap
                next_s.err_off = '0;
            end
            if (s.sw_path[SW_PATH_EN_BIT])
            begin
                next_s.path_start = 1'b1;
                next_s.path_num = s.sw_path[7:0];
            end
        end
        next_s.fb = fb_new;
        next_s.err = cmd_pos_i - fb_new - next_s.err_off;

        // sticky status: set wins over a write-one clear
        if (wr_hit_irq)
        begin
            next_s.irq_st = s.irq_st & ~req_i.wdata[IRQ_W-1:0];
        end
        next_s.irq_st = next_s.irq_st | irq_set;

        // reads answer one cycle later, unmapped reads give zero
        if (req_i.rd)
        begin
            case (req_i.addr)
                ADDR_BLEND_TC: next_s.rdata = s.blend_tc;
                ADDR_EXCESS_TOL: next_s.rdata = s.excess_tol;
                ADDR_SW_POLICY: next_s.rdata = {15'h0000, s.policy};
                ADDR_AUTO_RESET: next_s.rdata = s.auto_tol;
                ADDR_SW_PATH: next_s.rdata = s.sw_path;
                ADDR_ASSIST: next_s.rdata = s.assist;
                ADDR_HOME_SRC: next_s.rdata = s.home_src;
                ADDR_CAPTURE: next_s.rdata = s.capture;
                ADDR_IRQ_STATUS: next_s.rdata = {12'h000, s.irq_st};
                ADDR_IRQ_MASK: next_s.rdata = {12'h000, s.irq_mask};
                ADDR_STATE: next_s.rdata = {11'h000, s.hstate, s.clr_s2, s.semi};
                ADDR_DEV_LO: next_s.rdata = diff[15:0];
                ADDR_DEV_HI: next_s.rdata = diff[31:16];
                default: next_s.rdata = '0;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            s <= '0;
            s.blend_tc <= RST_BLEND_TC;
            s.excess_tol <= RST_EXCESS_TOL;
            s.policy <= RST_SW_POLICY[0];
            s.auto_tol <= RST_AUTO_RESET;
            s.sw_path <= RST_SW_PATH;
            s.assist <= RST_ASSIST;
            s.home_src <= RST_HOME_SRC;
            s.capture <= RST_CAPTURE;
            s.hstate <= H_IDLE;
        end
        else
        begin
            s <= next_s;
        end
    end

    // outputs
    assign rdata_o = s.rdata;
    assign fb_pos_o = s.fb;
    assign pos_err_o = s.err;
    assign semi_closed_o = s.semi;
    assign path_start_o = s.path_start;
    assign path_program_number_o = s.path_num;
    assign soft_limit_en_o = (s.hstate == H_IDLE);
    assign excess_deviation_alarm_o = s.irq_st[IRQ_EXCESS];
    assign scale_link_lost_alarm_o = s.irq_st[IRQ_LINK_LOST];
    assign irq_o = |(s.irq_st & s.irq_mask);
endmodule

// ---- tb/fclpc_sva.sv ----
// port-level assertions for the full-closed loop position control block
`timescale 1ns/1ns
module fclpc_sva
(
    input wire logic clk_i, // clock
    input wire logic rstn_i, // reset, active low
    input wire fclpc_pkg::fclpc_req_t req_i, // register request
    input wire logic [fclpc_pkg::DATA_W-1:0] rdata_o, // read data
    input wire logic [fclpc_pkg::POS_W-1:0] pos_err_o, // position error
    input wire logic semi_closed_o, // loop type
    input wire logic path_start_o, // path start pulse
    input wire logic homing_i, // homing level
    input wire logic soft_limit_en_o, // limits active
    input wire logic excess_deviation_alarm_o, // deviation alarm
    input wire logic scale_link_lost_alarm_o // link alarm
);
    import fclpc_pkg::*;
    logic pol;
    logic lnk;
    logic lnk_full;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    // shadows of policy and link detect, followed from the writes
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            pol <= 1'b0;
            lnk <= 1'b0;
        end
        else if (req_i.wr && req_i.addr == ADDR_SW_POLICY)
            pol <= req_i.wdata[0];
        else if (req_i.wr && req_i.addr == ADDR_ASSIST)
            lnk <= req_i.wdata[ASSIST_LINK_DET_BIT];
    end
    // watchdog may only count in full loop with detection on
    assign lnk_full = lnk && !semi_closed_o;
    a_blend_clamp: assert property (req_i.wr && req_i.addr == ADDR_BLEND_TC &&
        req_i.wdata > MAX_BLEND_TC ##2 req_i.rd && req_i.addr == ADDR_BLEND_TC
        |=> rdata_o == MAX_BLEND_TC) else $error("blend constant not clamped");
    a_path_on_switch: assert property (path_start_o |-> $changed(semi_closed_o))
        else $error("path start without loop switch");
    a_path_one_cycle: assert property (path_start_o |=> !path_start_o)
        else $error("path start longer than one cycle");
    a_policy_clear: assert property ($changed(semi_closed_o) && !pol
        |-> ##[0:1] pos_err_o == '0) else $error("position error kept under policy 0");
    a_limit_off_home: assert property (homing_i [*2] |-> !soft_limit_en_o)
        else $error("soft limits active while homing");
    a_limit_back_idle: assert property (!homing_i [*3] |-> soft_limit_en_o)
        else $error("soft limits not restored");
    a_link_needs_det: assert property ($rose(scale_link_lost_alarm_o) |-> $past(lnk_full))
        else $error("link alarm without detection");
    a_excess_sticky: assert property (excess_deviation_alarm_o && !(req_i.wr &&
        req_i.addr == ADDR_IRQ_STATUS && req_i.wdata[IRQ_EXCESS]) |=> excess_deviation_alarm_o)
        else $error("deviation alarm dropped");
endmodule

// ---- tb/fclpc_far.sv ----
// model of the encoder and linear scale feeding the block
`timescale 1ns/1ns
module fclpc_far
(
    input wire logic clk_i, // clock
    input wire logic rstn_i, // reset, active low
    input wire logic stall_i, // break the scale link
    input wire logic drift_i, // let the scale slip
    output logic [fclpc_pkg::POS_W-1:0] enc_pos_o, // encoder position
    output logic [fclpc_pkg::POS_W-1:0] scale_pos_o, // scale position
    output logic scale_valid_o // frame pulse
);
    import fclpc_pkg::*;
    logic [1:0] ph;
    // a frame every fourth cycle; a broken link shows a toggling bus
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            ph <= 2'h0;
            enc_pos_o <= 32'h00001000;
            scale_pos_o <= 32'h00001010;
            scale_valid_o <= 1'b0;
        end
        else
        begin
            ph <= ph + 2'h1;
            scale_valid_o <= ph == 2'h3 && !stall_i;
            if (stall_i)
                scale_pos_o <= ~scale_pos_o;
            else if (ph == 2'h3 && drift_i)
                scale_pos_o <= scale_pos_o + 32'h00000100;
        end
    end
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the full-closed loop position control block
`timescale 1ns/1ns
module tb_top;
    import fclpc_pkg::*;
    localparam logic [11:0] RA [5] = '{ADDR_BLEND_TC, ADDR_SW_POLICY, ADDR_ASSIST,
        ADDR_CAPTURE, 12'hffe};
    localparam logic [15:0] RV [5] = '{16'h0064, 16'h0000, 16'h0000, 16'h0001, 16'h0000};
    logic clk = 1'b0;
    logic rstn, lsel, dclr, hom, stall, drift, sv, semi, ps, sl, exa, lka, irq, rdp;
    logic [15:0] rdata, v;
    logic [7:0] pn, n;
    logic [31:0] cmd, enc, scl, fb, perr;
    logic [31:0] seed = 32'h8f223c3e;
    fclpc_req_t req;
    logic [15:0] expq[$];
    logic [11:0] adrq[$];
    int fail_count = 0;
    int num_checks = 0;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // one idle cycle after each access keeps every strobe a single pulse
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        req <= '0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [15:0] e);
        @(posedge clk);
        expq.push_back(e);
        adrq.push_back(a);
        req <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge clk);
        req <= '0;
    endtask
    function automatic logic hit(input int k);
        return k == 0 ? ps : (k == 1 ? exa : lka);
    endfunction
    task automatic till(input int k);
        for (int i = 0; i < 400 && hit(k) !== 1'b1; i++)
            @(negedge clk);
        if (hit(k) !== 1'b1)
        begin
            fail_count++;
            $display("wrong value wait %0d expected 1 seen 0", k);
            conclude();
        end
    endtask
    task automatic nap(input int c);
        repeat (c) @(negedge clk);
    endtask
    // read data are looked at only in the cycle after the strobe
    always @(posedge clk)
        rdp <= req.rd;
    always @(negedge clk)
        if (rdp === 1'b1 && expq.size() > 0)
            chk($sformatf("reg %h", adrq.pop_front()), {16'h0, expq.pop_front()}, {16'h0, rdata});
    initial forever #25 clk = ~clk;
    fclpc_far u_far (.clk_i(clk), .rstn_i(rstn), .stall_i(stall), .drift_i(drift),
        .enc_pos_o(enc), .scale_pos_o(scl), .scale_valid_o(sv));
    fclpc_ctrl #(.CTRL_CYC(16), .LINK_CYC(8)) u_dut (.clk_i(clk), .rstn_i(rstn), .req_i(req),
        .rdata_o(rdata), .loop_select_input_i(lsel), .deviation_clear_input_i(dclr),
        .enc_pos_i(enc), .scale_pos_i(scl), .scale_valid_i(sv), .cmd_pos_i(cmd),
        .homing_i(hom), .fb_pos_o(fb), .pos_err_o(perr), .semi_closed_o(semi),
        .path_start_o(ps), .path_program_number_o(pn), .soft_limit_en_o(sl),
        .excess_deviation_alarm_o(exa), .scale_link_lost_alarm_o(lka), .irq_o(irq));
    initial
    begin
        {rstn, lsel, dclr, hom, stall, drift} = 6'h00;
        req = '0;
        cmd = 32'h00002000;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        foreach (RA[i]) rd(RA[i], RV[i]);
        wr(ADDR_BLEND_TC, 16'h07d0);
        rd(ADDR_BLEND_TC, MAX_BLEND_TC);
        seed = xs(seed);
        v = seed[15:0] % 16'h03e9;
        wr(ADDR_BLEND_TC, v);
        rd(ADDR_BLEND_TC, v);
        wr(ADDR_BLEND_TC, 16'h0000);
        nap(40);
        chk("fb pure scale", 32'h00001010, fb);
        rd(ADDR_DEV_LO, 16'h0010);
        @(posedge clk);
        dclr <= 1'b1;
        nap(8);
        rd(ADDR_DEV_LO, 16'h0000);
        rd(ADDR_DEV_HI, 16'h0000);
        chk("fb rebased", enc, fb);
        $display("test registers and feedback done");
        seed = xs(seed);
        n = seed[7:0];
        wr(ADDR_SW_PATH, {8'h80, n});
        @(posedge clk);
        lsel <= 1'b1;
        till(0);
        chk("semi", 32'h1, {31'h0, semi});
        chk("path number", {24'h0, n}, {24'h0, pn});
        nap(2);
        chk("err cleared", 32'h0, perr);
        rd(ADDR_IRQ_STATUS, 16'h0004);
        nap(1);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(ADDR_IRQ_MASK, 16'h0004);
        nap(1);
        chk("irq on", 32'h1, {31'h0, irq});
        wr(ADDR_IRQ_STATUS, 16'h0004);
        nap(1);
        chk("irq off", 32'h0, {31'h0, irq});
        rd(ADDR_IRQ_STATUS, 16'h0000);
        wr(ADDR_SW_POLICY, 16'h0001);
        @(posedge clk);
        lsel <= 1'b0;
        till(0);
        nap(2);
        chk("err kept full", cmd - enc, perr);
        @(posedge clk);
        lsel <= 1'b1;
        till(0);
        nap(2);
        chk("err kept semi", cmd - enc, perr);
        @(posedge clk);
        lsel <= 1'b0;
        till(0);
        $display("test loop switching done");
        wr(ADDR_EXCESS_TOL, 16'h0040);
        drift <= 1'b1;
        till(1);
        @(posedge clk);
        drift <= 1'b0;
        wr(ADDR_HOME_SRC, 16'h0001);
        @(posedge clk);
        hom <= 1'b1;
        nap(4);
        chk("limits homing", 32'h0, {31'h0, sl});
        rd(ADDR_CAPTURE, 16'h0000);
        hom <= 1'b0;
        nap(4);
        chk("limits idle", 32'h1, {31'h0, sl});
        rd(ADDR_CAPTURE, 16'h0000);
        rd(ADDR_IRQ_STATUS, 16'h000d);
        rd(ADDR_DEV_LO, 16'h0000);
        wr(ADDR_BLEND_TC, 16'h0001);
        drift <= 1'b1;
        repeat (4) @(posedge clk);
        drift <= 1'b0;
        nap(1);
        chk("fb lags step", 32'h1, {31'h0, fb !== enc + 32'h00000100});
        nap(1200);
        chk("fb settled", enc + 32'h00000100, fb);
        wr(ADDR_AUTO_RESET, 16'h0200);
        nap(40);
        chk("fb auto reset", enc, fb);
        rd(ADDR_DEV_LO, 16'h0000);
        wr(ADDR_AUTO_RESET, 16'h0000);
        $display("test blend and auto reset done");
        wr(ADDR_IRQ_STATUS, 16'h000f);
        $display("test deviation and homing done");
        stall <= 1'b1;
        nap(30);
        chk("no link alarm", 32'h0, {31'h0, lka});
        wr(ADDR_ASSIST, 16'h0020);
        till(2);
        $display("test scale link done");
        conclude();
    end
endmodule
bind fclpc_ctrl fclpc_sva u_sva (.clk_i(clk_i), .rstn_i(rstn_i), .req_i(req_i),
    .rdata_o(rdata_o), .pos_err_o(pos_err_o), .semi_closed_o(semi_closed_o),
    .path_start_o(path_start_o), .homing_i(homing_i), .soft_limit_en_o(soft_limit_en_o),
    .excess_deviation_alarm_o(excess_deviation_alarm_o),
    .scale_link_lost_alarm_o(scale_link_lost_alarm_o));
